//--- core/twp_pkg.sv
// Purpose: shared constants and types for the transparent window and probe status block
// Assumes: one processor clock, control-register moves and memory ops arrive as pulses
// Notes: field positions follow the window and probe status register layouts
package twp_pkg;
  // register selects for the control-register move port
  localparam logic [2:0] SEL_USER_ROOT = 3'h0; // user_root_pointer, held elsewhere, reads zero
  localparam logic [2:0] SEL_SUPER_ROOT = 3'h1; // supervisor_root_pointer, reads zero here
  localparam logic [2:0] SEL_XLAT_CTRL = 3'h2; // translation_control
  localparam logic [2:0] SEL_PROBE_STATUS = 3'h3; // translation_probe_result
  localparam logic [2:0] SEL_DATA_WIN0 = 3'h4; // data_window_zero, windows 4..7 by low bits
  localparam logic [2:0] SEL_DATA_WIN1 = 3'h5; // data_window_one
  localparam logic [2:0] SEL_FETCH_WIN0 = 3'h6; // fetch_window_zero
  localparam logic [2:0] SEL_FETCH_WIN1 = 3'h7; // fetch_window_one
  // transparent window field positions
  localparam int WIN_BASE_HI = 31;
  localparam int WIN_BASE_LO = 24;
  localparam int WIN_MASK_HI = 23;
  localparam int WIN_MASK_LO = 16;
  localparam int WIN_EN = 15;
  localparam int WIN_PRIV_HI = 14;
  localparam int WIN_PRIV_LO = 13;
  localparam int WIN_U1 = 9;
  localparam int WIN_U0 = 8;
  localparam int WIN_CM_HI = 6;
  localparam int WIN_CM_LO = 5;
  localparam int WIN_WP = 2;
  // translation control bits
  localparam int TC_EN = 15;
  localparam int TC_PAGE8K = 14;
  localparam int TC_W = 16;
  // probe status field positions
  localparam int ST_PA_HI = 31;
  localparam int ST_PA_LO = 12;
  localparam int ST_BERR = 11;
  localparam int ST_G = 10;
  localparam int ST_U1 = 9;
  localparam int ST_U0 = 8;
  localparam int ST_S = 7;
  localparam int ST_CM_HI = 6;
  localparam int ST_CM_LO = 5;
  localparam int ST_M = 4;
  localparam int ST_W = 2;
  localparam int ST_T = 1;
  localparam int ST_R = 0;
  // privilege qualifier codes and cache modes
  localparam logic [1:0] PRIV_USER = 2'h0;
  localparam logic [1:0] PRIV_SUPER = 2'h1;
  localparam logic [1:0] CM_WRITETHROUGH = 2'h0;
  localparam logic [1:0] FC_PROGRAM = 2'h2; // low function code bits of a fetch
  localparam int FC_PRIV = 2; // privilege_code_bit position in a function code
  localparam int ENTRIES = 8; // translation cache depth
  localparam int PTR_W = 3;
  localparam int NWIN = 4;
  // memory-unit operations
  typedef enum logic [2:0] {
    TWP_OP_INV_ALL = 3'h0, // invalidate_all_op
    TWP_OP_INV_ALL_NG = 3'h1, // all_nonglobal_invalidate_op
    TWP_OP_INV_SEL = 3'h2, // selective_invalidate_op
    TWP_OP_INV_SEL_NG = 3'h3, // selective_nonglobal_invalidate_op
    TWP_OP_PROBE = 3'h4 // probe_translation_op
  } twp_op_e;
  // probe sequence, gray along idle-inval-walk-load
  typedef enum logic [1:0] {
    TWP_IDLE = 2'h0,
    TWP_INVAL = 2'h1,
    TWP_WALK = 2'h3,
    TWP_LOAD = 2'h2
  } twp_fsm_e;
  typedef struct packed {
    logic valid;
    twp_op_e kind;
    logic [31:0] addr;
    logic [2:0] dest_function_code;
  } twp_op_s;
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [2:0] fc;
    logic write;
    logic rmw;
  } twp_acc_s;
  typedef struct packed {
    logic done;
    logic fault; // write protect or invalid entry fault on this access
    logic miss; // translation enabled, nothing resident
    logic [31:0] phys;
    logic [1:0] cache_policy_field;
    logic user_attr_out_zero;
    logic user_attr_out_one;
  } twp_rsp_s;
  typedef struct packed {
    logic done;
    logic err; // transfer error during the search
    logic valid; // search ended on a valid page descriptor
    logic [19:0] phys;
    logic g;
    logic u1;
    logic u0;
    logic s;
    logic [1:0] cm;
    logic m;
    logic w_any; // write protect seen on any descriptor
  } twp_walk_s;
  typedef struct packed {
    logic valid;
    logic [19:0] tag;
    logic priv_space; // entry belongs to the supervisor tree
    logic fetch;
    logic [19:0] phys;
    logic g;
    logic u1;
    logic u0;
    logic s;
    logic [1:0] cm;
    logic w;
    logic r;
  } twp_entry_s;
  typedef struct packed {
    twp_fsm_e fsm;
    logic [TC_W-1:0] tc;
    logic [NWIN-1:0][31:0] win;
    logic [31:0] status;
    twp_entry_s [ENTRIES-1:0] cache;
    logic [PTR_W-1:0] fill_ptr;
    logic [31:0] p_addr;
    logic [2:0] p_fc;
    logic [31:0] rdata;
    twp_rsp_s rsp;
    logic op_done;
    logic busy;
    logic fline;
    logic walk_req;
  } twp_state_s;
endpackage

//--- core/twp_window_match.sv
// Purpose: one transparent window compare against an address and privilege bit
// Assumes: window word in the transparent window layout
// Notes: purely combinational, the caller registers the result
`timescale 1ns/100ps
module twp_window_match (
  input wire logic [31:0] window,
  input wire logic [7:0] addr_hi,
  input wire logic priv,
  output logic hit
);
  logic [7:0] care; // bits that take part in the compare
  logic priv_ok;
  // base compare, privilege qualifier and enable
  always_comb begin
    care = ~window[twp_pkg::WIN_MASK_HI:twp_pkg::WIN_MASK_LO];
    case (window[twp_pkg::WIN_PRIV_HI:twp_pkg::WIN_PRIV_LO])
      twp_pkg::PRIV_USER: priv_ok = ~priv;
      twp_pkg::PRIV_SUPER: priv_ok = priv;
      default: priv_ok = 1'b1; // 1x ignores privilege
    endcase
    hit = window[twp_pkg::WIN_EN] & priv_ok &
          (((addr_hi ^ window[twp_pkg::WIN_BASE_HI:twp_pkg::WIN_BASE_LO]) & care) == 8'h00);
  end
endmodule

//--- core/twp_mmu_core.sv
// Purpose: transparent windows, translation cache, flushes and probe status
// Assumes: control moves and ops come from privileged processor logic on mclk
// Notes: translation cache contents survive reset; software flushes after reset
`timescale 1ns/100ps
module twp_mmu_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ctl_wr,
  input wire logic ctl_rd,
  input wire logic [2:0] ctl_sel,
  input wire logic [31:0] ctl_wdata,
  output logic [31:0] ctl_rdata,
  input wire twp_pkg::twp_op_s op,
  output logic op_done,
  output logic op_busy,
  input wire logic legacy_op,
  output logic fline_exc,
  input wire twp_pkg::twp_acc_s acc,
  output twp_pkg::twp_rsp_s rsp,
  output logic walk_req,
  output logic [31:0] walk_addr,
  output logic [2:0] walk_fc,
  input wire twp_pkg::twp_walk_s walk
);
  twp_pkg::twp_state_s st; // every register of the block
  twp_pkg::twp_state_s next_st;
  logic [3:0] acc_match; // per window, current access
  logic [3:0] probe_match; // per window, probed address

  // first matching window of a pair, window zero wins
  function automatic logic [1:0] pick_win(input logic [3:0] m, input logic fetch);
    logic [1:0] base;
    base = fetch ? 2'h2 : 2'h0;
    if (m[base]) begin
      pick_win = base;
    end else begin
      pick_win = base | 2'h1;
    end
  endfunction

  // selective flush decode, shared by flush and probe invalidate
  function automatic logic sel_hit(input twp_pkg::twp_entry_s e, input logic [31:0] a,
                                   input logic space);
    sel_hit = e.valid && (e.tag == a[31:12]) && (e.priv_space == space);
  endfunction

  // window compares, one set for accesses and one for the probe
  generate
    for (genvar w = 0; w < twp_pkg::NWIN; w++) begin : g_win
      twp_window_match u_acc (
        .window(st.win[w]),
        .addr_hi(acc.addr[31:24]),
        .priv(acc.fc[twp_pkg::FC_PRIV]),
        .hit(acc_match[w])
      );
      twp_window_match u_probe (
        .window(st.win[w]),
        .addr_hi(st.p_addr[31:24]),
        .priv(st.p_fc[twp_pkg::FC_PRIV]),
        .hit(probe_match[w])
      );
    end
  endgenerate

  // next-state logic for the whole block
  always_comb begin
    logic fetch;
    logic [1:0] widx;
    logic win_hit;
    logic is_wr;
    logic c_hit;
    logic p_fetch;
    twp_pkg::twp_entry_s ce;
    logic [31:0] wv;
    fetch = 1'b0;
    widx = 2'h0;
    win_hit = 1'b0;
    is_wr = 1'b0;
    c_hit = 1'b0;
    p_fetch = 1'b0;
    ce = '0;
    wv = '0;
    next_st = st;
    // pulses default low
    next_st.rsp.done = 1'b0;
    next_st.rsp.fault = 1'b0;
    next_st.rsp.miss = 1'b0;
    next_st.op_done = 1'b0;
    next_st.fline = legacy_op;

    // control-register moves; cache is not touched by these
    // no flush on access
    if (ctl_wr) begin
      case (ctl_sel)
        twp_pkg::SEL_XLAT_CTRL: next_st.tc = ctl_wdata[twp_pkg::TC_W-1:0];
        twp_pkg::SEL_PROBE_STATUS: next_st.status = ctl_wdata;
        twp_pkg::SEL_DATA_WIN0, twp_pkg::SEL_DATA_WIN1,
        twp_pkg::SEL_FETCH_WIN0, twp_pkg::SEL_FETCH_WIN1: next_st.win[ctl_sel[1:0]] = ctl_wdata;
        default: ; // root pointers live outside this block
      endcase
    end
    if (ctl_rd) begin
      case (ctl_sel)
        twp_pkg::SEL_XLAT_CTRL: next_st.rdata = {16'h0000, st.tc};
        twp_pkg::SEL_PROBE_STATUS: next_st.rdata = st.status;
        twp_pkg::SEL_DATA_WIN0, twp_pkg::SEL_DATA_WIN1,
        twp_pkg::SEL_FETCH_WIN0, twp_pkg::SEL_FETCH_WIN1: next_st.rdata = st.win[ctl_sel[1:0]];
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end

    // access translation, answered one cycle after the request
    if (acc.valid) begin
      fetch = (acc.fc[1:0] == twp_pkg::FC_PROGRAM);
      widx = pick_win(acc_match, fetch);
      win_hit = fetch ? |acc_match[3:2] : |acc_match[1:0];
      is_wr = acc.write | acc.rmw;
      for (int i = 0; i < twp_pkg::ENTRIES; i++) begin
        if (sel_hit(st.cache[i], acc.addr, acc.fc[twp_pkg::FC_PRIV]) &&
            (st.cache[i].fetch == fetch)) begin
          c_hit = 1'b1;
          ce = st.cache[i];
        end
      end
      next_st.rsp.done = 1'b1;
      wv = st.win[widx];
      if (win_hit) begin
        next_st.rsp.phys = acc.addr;
        next_st.rsp.cache_policy_field = wv[twp_pkg::WIN_CM_HI:twp_pkg::WIN_CM_LO];
        next_st.rsp.user_attr_out_zero = wv[twp_pkg::WIN_U0];
        next_st.rsp.user_attr_out_one = wv[twp_pkg::WIN_U1];
        next_st.rsp.fault = wv[twp_pkg::WIN_WP] & is_wr;
      end else if (st.tc[twp_pkg::TC_EN] && c_hit) begin
        next_st.rsp.phys = {ce.phys, acc.addr[11:0]};
        next_st.rsp.cache_policy_field = ce.cm;
        next_st.rsp.user_attr_out_zero = ce.u0;
        next_st.rsp.user_attr_out_one = ce.u1;
        next_st.rsp.fault = ~ce.r | (ce.w & is_wr);
      end else if (st.tc[twp_pkg::TC_EN]) begin
        // no entry: the core must probe and retry
        next_st.rsp.miss = 1'b1;
        next_st.rsp.phys = acc.addr;
        next_st.rsp.cache_policy_field = twp_pkg::CM_WRITETHROUGH;
        next_st.rsp.user_attr_out_zero = 1'b0;
        next_st.rsp.user_attr_out_one = 1'b0;
      end else begin
        // untranslated default attributes
        next_st.rsp.phys = acc.addr;
        next_st.rsp.cache_policy_field = twp_pkg::CM_WRITETHROUGH;
        next_st.rsp.user_attr_out_zero = 1'b0;
        next_st.rsp.user_attr_out_one = 1'b0;
      end
    end

    // flushes and the probe sequence
    p_fetch = (st.p_fc[1:0] == twp_pkg::FC_PROGRAM);
    case (st.fsm)
      twp_pkg::TWP_IDLE: begin
        // ops arriving while busy are ignored, see op_busy
        if (op.valid) begin
          for (int i = 0; i < twp_pkg::ENTRIES; i++) begin
            case (op.kind)
              twp_pkg::TWP_OP_INV_ALL: next_st.cache[i].valid = 1'b0;
              twp_pkg::TWP_OP_INV_ALL_NG:
                if (!st.cache[i].g) next_st.cache[i].valid = 1'b0;
              twp_pkg::TWP_OP_INV_SEL:
                if (sel_hit(st.cache[i], op.addr, op.dest_function_code[twp_pkg::FC_PRIV]))
                  next_st.cache[i].valid = 1'b0;
              twp_pkg::TWP_OP_INV_SEL_NG:
                if (sel_hit(st.cache[i], op.addr, op.dest_function_code[twp_pkg::FC_PRIV]) &&
                    !st.cache[i].g) next_st.cache[i].valid = 1'b0;
              default: ;
            endcase
          end
          if (op.kind == twp_pkg::TWP_OP_PROBE) begin
            next_st.p_addr = op.addr;
            next_st.p_fc = op.dest_function_code;
            next_st.fsm = twp_pkg::TWP_INVAL;
            next_st.busy = 1'b1;
          end else begin
            next_st.op_done = 1'b1;
          end
        end
      end
      twp_pkg::TWP_INVAL: begin
        for (int i = 0; i < twp_pkg::ENTRIES; i++) begin
          if (sel_hit(st.cache[i], st.p_addr, st.p_fc[twp_pkg::FC_PRIV]) &&
              (st.cache[i].fetch == p_fetch)) next_st.cache[i].valid = 1'b0;
        end
        if (|probe_match) begin
          next_st.status = 32'h0000_0000;
          next_st.status[twp_pkg::ST_T] = 1'b1;
          next_st.status[twp_pkg::ST_R] = 1'b1;
          next_st.fsm = twp_pkg::TWP_IDLE;
          next_st.busy = 1'b0;
          next_st.op_done = 1'b1;
        end else begin
          next_st.walk_req = 1'b1;
          next_st.fsm = twp_pkg::TWP_WALK;
        end
      end
      twp_pkg::TWP_WALK: begin
        if (walk.done) begin
          next_st.walk_req = 1'b0;
          next_st.status = 32'h0000_0000;
          if (walk.err) begin
            next_st.status[twp_pkg::ST_BERR] = 1'b1;
            next_st.fsm = twp_pkg::TWP_IDLE;
            next_st.busy = 1'b0;
            next_st.op_done = 1'b1;
          end else begin
            next_st.status[twp_pkg::ST_PA_HI:twp_pkg::ST_PA_LO] = walk.phys;
            next_st.status[twp_pkg::ST_G] = walk.g;
            next_st.status[twp_pkg::ST_U1] = walk.u1;
            next_st.status[twp_pkg::ST_U0] = walk.u0;
            next_st.status[twp_pkg::ST_S] = walk.s;
            next_st.status[twp_pkg::ST_M] = walk.m;
            next_st.status[twp_pkg::ST_CM_HI:twp_pkg::ST_CM_LO] = walk.cm;
            next_st.status[twp_pkg::ST_W] = walk.w_any;
            next_st.status[twp_pkg::ST_R] = walk.valid;
            next_st.fsm = twp_pkg::TWP_LOAD;
          end
        end
      end
      twp_pkg::TWP_LOAD: begin
        ce.valid = 1'b1;
        ce.tag = st.p_addr[31:12];
        ce.priv_space = st.p_fc[twp_pkg::FC_PRIV];
        ce.fetch = p_fetch;
        ce.phys = st.status[twp_pkg::ST_PA_HI:twp_pkg::ST_PA_LO];
        ce.g = st.status[twp_pkg::ST_G];
        ce.u1 = st.status[twp_pkg::ST_U1];
        ce.u0 = st.status[twp_pkg::ST_U0];
        ce.s = st.status[twp_pkg::ST_S];
        ce.cm = st.status[twp_pkg::ST_CM_HI:twp_pkg::ST_CM_LO];
        ce.w = st.status[twp_pkg::ST_W];
        ce.r = st.status[twp_pkg::ST_R];
        next_st.cache[st.fill_ptr] = ce;
        // round-robin replacement, cheap and fair enough for a small cache
        next_st.fill_ptr = st.fill_ptr + 3'h1;
        next_st.fsm = twp_pkg::TWP_IDLE;
        next_st.busy = 1'b0;
        next_st.op_done = 1'b1;
      end
      default: next_st.fsm = twp_pkg::TWP_IDLE;
    endcase

    // synchronous reset: enables off, cache contents kept on purpose
    if (rst) begin
      next_st.tc[twp_pkg::TC_EN] = 1'b0;
      next_st.tc[twp_pkg::TC_PAGE8K] = 1'b1;
      for (int w = 0; w < twp_pkg::NWIN; w++) begin
        next_st.win[w][twp_pkg::WIN_EN] = 1'b0;
      end
      next_st.fsm = twp_pkg::TWP_IDLE;
      next_st.fill_ptr = '0;
      next_st.rdata = 32'h0000_0000;
      next_st.rsp = '0;
      next_st.op_done = 1'b0;
      next_st.busy = 1'b0;
      next_st.fline = 1'b0;
      next_st.walk_req = 1'b0;
      next_st.p_addr = 32'h0000_0000;
      next_st.p_fc = 3'h0;
    end
  end

  // single state register
  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  // outputs straight from the state register
  assign ctl_rdata = st.rdata;
  assign op_done = st.op_done;
  assign op_busy = st.busy;
  assign fline_exc = st.fline;
  assign rsp = st.rsp;
  assign walk_req = st.walk_req;
  assign walk_addr = st.p_addr;
  assign walk_fc = st.p_fc;

  // checks
  logic data_wp_write;
  assign data_wp_write = acc.valid && (acc.fc[1:0] != twp_pkg::FC_PROGRAM) && acc_match[0] &&
                         st.win[0][twp_pkg::WIN_WP] && (acc.write || acc.rmw);

  property p_wp_abort;
    @(posedge mclk) disable iff (rst) data_wp_write |=> rsp.done && rsp.fault;
  endproperty
  a_wp_abort: assert property (p_wp_abort) else $error("window write not aborted");

  property p_attr_echo;
    @(posedge mclk) disable iff (rst)
      acc.valid && acc_match[0] && (acc.fc[1:0] != twp_pkg::FC_PROGRAM) |=>
      rsp.user_attr_out_zero == $past(st.win[0][twp_pkg::WIN_U0]) &&
      rsp.cache_policy_field == $past(st.win[0][twp_pkg::WIN_CM_HI:twp_pkg::WIN_CM_LO]);
  endproperty
  a_attr_echo: assert property (p_attr_echo) else $error("window attributes not echoed");

  property p_disabled_win;
    @(posedge mclk) disable iff (rst) acc_match[1] |-> st.win[1][twp_pkg::WIN_EN];
  endproperty
  a_disabled_win: assert property (p_disabled_win) else $error("disabled window hit");

  property p_berr_only;
    @(posedge mclk) disable iff (rst)
      st.fsm == twp_pkg::TWP_WALK && walk.done && walk.err |=>
      st.status == 32'h0000_0800 && op_done;
  endproperty
  a_berr_only: assert property (p_berr_only) else $error("bus error status wrong");

  property p_tt_hit;
    @(posedge mclk) disable iff (rst)
      st.fsm == twp_pkg::TWP_INVAL && |probe_match |=> st.status == 32'h0000_0003 && !walk_req;
  endproperty
  a_tt_hit: assert property (p_tt_hit) else $error("window hit status wrong");

  property p_reset_en;
    @(posedge mclk) rst |=> !st.tc[twp_pkg::TC_EN] && !st.win[0][twp_pkg::WIN_EN] &&
                           !st.win[3][twp_pkg::WIN_EN];
  endproperty
  a_reset_en: assert property (p_reset_en) else $error("enable survived reset");

  property p_fline;
    @(posedge mclk) disable iff (rst) legacy_op |=> fline_exc;
  endproperty
  a_fline: assert property (p_fline) else $error("legacy opcode not trapped");

  property p_flush_all;
    @(posedge mclk) disable iff (rst)
      op.valid && op.kind == twp_pkg::TWP_OP_INV_ALL && !st.busy |=>
      st.cache[0].valid == 1'b0 && st.cache[7].valid == 1'b0 && op_done;
  endproperty
  a_flush_all: assert property (p_flush_all) else $error("flush all left entries");

  property p_walk_held;
    @(posedge mclk) disable iff (rst)
      walk_req && !(st.fsm == twp_pkg::TWP_WALK && walk.done) |=> walk_req;
  endproperty
  a_walk_held: assert property (p_walk_held) else $error("search request dropped");

  c_probe_ok: cover property (@(posedge mclk) disable iff (rst)
    st.fsm == twp_pkg::TWP_LOAD ##1 op_done);
  c_probe_tt: cover property (@(posedge mclk) disable iff (rst) st.status[twp_pkg::ST_T]);
  c_wp_fault: cover property (@(posedge mclk) disable iff (rst) rsp.fault);
endmodule

//--- bench/tb.sv
// Purpose: self-checking bench for the transparent window and probe status core
// Assumes: inputs driven 1 ns after the rising edge of mclk
// Notes: a small integer model predicts every answer; the cache starts unknown, so flush first
`timescale 1ns/100ps
module tb;
  logic mclk, rst, ctl_wr, ctl_rd, legacy_op, op_done, op_busy, fline_exc, walk_req;
  logic [2:0] ctl_sel, walk_fc;
  logic [31:0] ctl_wdata, ctl_rdata, walk_addr, d;
  twp_pkg::twp_op_s op;
  twp_pkg::twp_acc_s acc;
  twp_pkg::twp_rsp_s rsp;
  twp_pkg::twp_walk_s walk;
  int failures, n_checks;
  logic [31:0] win [4]; // model copy of the four windows
  twp_mmu_core i_dut (.mclk(mclk), .rst(rst), .ctl_wr(ctl_wr), .ctl_rd(ctl_rd),
    .ctl_sel(ctl_sel), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .op(op),
    .op_done(op_done), .op_busy(op_busy), .legacy_op(legacy_op), .fline_exc(fline_exc),
    .acc(acc), .rsp(rsp), .walk_req(walk_req), .walk_addr(walk_addr), .walk_fc(walk_fc),
    .walk(walk));
  // clock, 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task step;
    @(posedge mclk);
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // strobe lowered then one idle edge, so no signal is set twice in one step
  task wr(input logic [2:0] s, input logic [31:0] v);
    ctl_wr = 1'b1; ctl_sel = s; ctl_wdata = v;
    step; ctl_wr = 1'b0; step;
  endtask
  task rd(input logic [2:0] s, output logic [31:0] v);
    ctl_rd = 1'b1; ctl_sel = s;
    step; ctl_rd = 1'b0; v = ctl_rdata; step;
  endtask
  // model of one window compare
  function automatic bit wm(logic [31:0] w, logic [31:0] a, logic p);
    return w[15] && ((w[31:24] ^ a[31:24]) & ~w[23:16]) == 8'h00 && (w[14] || w[13] == p);
  endfunction
  task automatic acc_go(input logic [31:0] a, input logic [2:0] fc, input logic w, m);
    logic [31:0] ww;
    bit hit;
    int b;
    hit = 0; ww = '0;
    b = (fc[1:0] == 2'h2) ? 2 : 0; // fetch windows sit at 2 and 3
    // window zero scanned last so it wins a double match
    for (int i = b + 1; i >= b; i--) if (wm(win[i], a, fc[2])) begin
      hit = 1; ww = win[i];
    end
    acc = '{1'b1, a, fc, w, m};
    step; acc.valid = 1'b0;
    chk(32'({rsp.done, rsp.fault, rsp.miss, rsp.cache_policy_field, rsp.user_attr_out_one,
      rsp.user_attr_out_zero}), 32'({1'b1, hit & ww[2] & (w | m), 1'b0, ww[6:5], ww[9],
      ww[8]}));
    chk(rsp.phys, a);
    step;
  endtask
  task automatic probe(input logic [31:0] a, input logic [2:0] fc, input bit err, hw);
    bit given;
    logic [31:0] e;
    given = 0;
    op = '{1'b1, twp_pkg::TWP_OP_PROBE, a, fc};
    step; op.valid = 1'b0;
    chk(32'(op_busy), 32'h1);
    for (int k = 0; k < 20 && !op_done; k++) begin
      if (walk.done) walk.done = 1'b0;
      else if (walk_req && !given) begin
        chk(walk_addr, a);
        chk(32'(walk_fc), 32'(fc));
        walk = twp_pkg::twp_walk_s'($urandom); walk.done = 1'b1; walk.err = err; given = 1;
      end
      step;
    end
    walk.done = 1'b0; // search side idles once answered
    chk(32'(op_done), 32'h1);
    // window hit, bus error, or fields copied from the last descriptor
    if (hw) e = 32'h3;
    else if (err) e = 32'h800;
    else e = {walk.phys, 1'b0, walk.g, walk.u1, walk.u0, walk.s, walk.cm, walk.m, 1'b0,
      walk.w_any, 1'b0, walk.valid};
    step; rd(3'h3, d);
    chk(d, e);
  endtask
  // translated user data write against the entry the last probe loaded
  task automatic tacc(input logic [31:0] a, input bit res);
    logic [31:0] e;
    e = res ? {walk.phys, a[11:0]} : a;
    acc = '{1'b1, a, 3'h1, 1'b1, 1'b0};
    step; acc.valid = 1'b0;
    chk(rsp.phys, e);
    chk(32'({rsp.done, rsp.fault, rsp.miss, rsp.cache_policy_field, rsp.user_attr_out_one,
      rsp.user_attr_out_zero}), 32'({1'b1, res & (!walk.valid | walk.w_any), !res,
      res ? walk.cm : 2'h0, res & walk.u1, res & walk.u0}));
    step;
  endtask
  // watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    finish_test;
  end
  initial begin
    rst = 1'b1; ctl_wr = 0; ctl_rd = 0; ctl_sel = '0; ctl_wdata = '0; legacy_op = 0;
    op = '0; acc = '0; walk = '0; failures = 0; n_checks = 0;
    void'($urandom(32'h84dd));
    repeat (5) @(posedge mclk);
    #1 rst = 1'b0;
    // every flush kind; first one clears the unknown cache
    for (int k = 0; k < 4; k++) begin
      op = '{1'b1, twp_pkg::twp_op_e'(k), $urandom, 3'h5};
      step; op.valid = 1'b0;
      for (int n = 0; n < 10 && !op_done; n++) step;
      chk(32'(op_done), 32'h1);
      step;
    end
    legacy_op = 1'b1; step; legacy_op = 1'b0;
    chk(32'(fline_exc), 32'h1);
    step;
    // random windows, read back, then accesses aimed at their bases
    for (int r = 0; r < 8; r++) begin
      for (int i = 0; i < 4; i++) begin
        win[i] = $urandom & 32'hffffe364; // reserved bits kept zero
        wr(3'(4 + i), win[i]); rd(3'(4 + i), d);
        chk(d, win[i]);
      end
      for (int n = 0; n < 16; n++)
        acc_go({win[$urandom % 4][31:24], 24'($urandom)}, 3'($urandom), 1'($urandom),
          1'($urandom));
    end
    win[2] = 32'h1200c000; wr(3'h6, win[2]);
    probe(32'h12345678, 3'h6, 0, 1);
    // reset mid-run drops window enables only
    rst = 1'b1; step; rst = 1'b0; step;
    for (int i = 0; i < 4; i++) begin
      rd(3'(4 + i), d); win[i][15] = 1'b0;
      chk(d, win[i]);
    end
    for (int k = 0; k < 6; k++) probe($urandom, 3'($urandom), k % 3 == 0, 0);
    // fresh entry, then translation on: the register write must leave the entry resident
    probe(32'h0abcd123, 3'h1, 0, 0);
    wr(3'h2, 32'h0000_8000);
    tacc(32'h0abcd123, 1);
    // nonglobal flush spares a global entry, plain selective flush removes it
    op = '{1'b1, twp_pkg::TWP_OP_INV_SEL_NG, 32'h0abcd123, 3'h1};
    step; op.valid = 1'b0;
    tacc(32'h0abcd123, walk.g);
    op = '{1'b1, twp_pkg::TWP_OP_INV_SEL, 32'h0abcd123, 3'h1};
    step; op.valid = 1'b0;
    tacc(32'h0abcd123, 0);
    finish_test;
  end
endmodule
